// file: core/kvl_regs.svh
`ifndef KVL_REGS_SVH
`define KVL_REGS_SVH
`define KVL_KEY_BITS 64
`define KVL_KEY_BYTES 8
`define KVL_SYMBOLS 16
`define KVL_SYM_BITS 4
`define KVL_FIFO_DEPTH 32
`define KVL_LAST_BIT_IDX 7'h3F
`define KVL_RESET_OPERABLE 1'h0
`endif

// file: core/kvl_pkg.sv
`include "kvl_regs.svh"
package kvl_pkg;
   typedef enum logic [2:0] {
      S_IDLE, S_MANUAL, S_REQ, S_CHECK, S_PUSH, S_DRAIN, S_STANDBY
   } kvl_state_e;

   // operator panel, synchronous to clk
   typedef struct packed {
      logic sym_valid;
      logic [3:0] sym_value;
      logic sym_back;
      logic restart;
      logic enter;
      logic load_req;
      logic standby_req;
      logic lock_turn;
   } kvl_panel_s;

   typedef struct packed {
      kvl_state_e st;
      logic [63:0] key;
      logic [63:0] disp;
      logic [6:0] cnt;
      logic [4:0] mcnt;
      logic [3:0] bidx;
      logic [3:0] didx;
      logic perr;
      logic xerr;
      logic loaded;
      logic operable;
      logic clk_m;
      logic clk_s;
      logic clk_d;
      logic dat_m;
      logic dat_s;
      logic use_m;
      logic use_s;
   } kvl_state_s;
endpackage : kvl_pkg

// file: core/kvl_loader.sv
`timescale 1ns/100ps
`include "kvl_regs.svh"
//
// Operation
// - a key is 64 bits, 56 key bits and 8 parity bits
// - every byte of the key has odd parity over all eight of its bits
// - ciphertext output is inhibited while a key moves into the core
// - the assembled key runs from first_key_bit to last_key_bit
// - manual entry takes 16 four-bit symbols, leftmost symbol first
// - operator can delete the last symbol or restart the whole key
// - displayed key digits clear automatically once the key is accepted
// - on the link first_key_bit comes first, ascending to last_key_bit
// - serial transfer starts only from an operator load request
// - request idles high and goes low to ask for a key
// - only the first 64 link clocks of a request are taken
// - spare circuits may claim data and clock lines for other use
// - loading works with the spare circuits left unused
// - standby keeps key, is inoperable, only the lock restores service
// - odd parity of each byte is checked at entry and internal transfer
////////////////////////////////////////////////////////////////////////////////
module kvl_fifo #(
   parameter int W = 8,
   parameter int D = `KVL_FIFO_DEPTH
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   if (D < 2 || (1 << AW) != D) begin : g_chk
      $error("kvl_fifo depth must be a power of two of at least 2");
   end
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } kvl_fifo_s;
   kvl_fifo_s q;
   kvl_fifo_s next_q;
   logic [W-1:0] mem [D];
   logic push;
   logic pop;

   assign in_ready = (q.cnt != (AW+1)'(D));
   assign out_valid = (q.cnt != '0);
   assign out_data = mem[q.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      next_q = q;
      if (push) begin
         next_q.wp = q.wp + 1'b1;
      end
      if (pop) begin
         next_q.rp = q.rp + 1'b1;
      end
      next_q.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   // storage needs no reset; only counted words are ever read
   always_ff @(posedge clk) begin
      if (push) begin
         mem[q.wp] <= in_data;
      end
   end
endmodule : kvl_fifo

////////////////////////////////////////////////////////////////////////////////
module kvl_loader
   import kvl_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire kvl_panel_s panel,
   input wire logic link_clk,
   input wire logic link_data,
   input wire logic link_other_use,
   output logic request_b,
   output logic core_valid,
   input wire logic core_ready,
   output logic [7:0] core_data,
   output logic ct_inhibit,
   output logic key_loaded,
   output logic parity_fail,
   output logic xfer_fail,
   output logic operable,
   output logic [63:0] disp_digits
);
   kvl_state_s q;
   kvl_state_s next_q;
   logic rst_m;
   logic rst_s;
   logic rise;
   logic push;
   logic push_ready;
   logic [7:0] push_data;
   logic take;

   function automatic logic kvl_odd(input logic [7:0] b);
      return ^b;
   endfunction : kvl_odd

   function automatic logic kvl_key_ok(input logic [63:0] k);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < `KVL_KEY_BYTES; i++) begin
         ok = ok & kvl_odd(k[8*i +: 8]);
      end
      return ok;
   endfunction : kvl_key_ok

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_m <= 1'b0;
         rst_s <= 1'b0;
      end else begin
         rst_m <= 1'b1;
         rst_s <= rst_m;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign rise = q.clk_s && !q.clk_d;
   assign take = core_valid && core_ready;
   assign push = (q.st == S_PUSH);
   assign push_data = q.key[63 - 8*q.bidx[2:0] -: 8];
   assign request_b = (q.st != S_REQ);
   assign ct_inhibit = !q.operable || (q.st inside {S_REQ, S_CHECK, S_PUSH, S_DRAIN});
   assign key_loaded = q.loaded;
   assign parity_fail = q.perr;
   assign xfer_fail = q.xerr;
   assign operable = q.operable;
   assign disp_digits = q.disp;

   always_comb begin
      next_q = q;
      next_q.clk_m = link_clk;
      next_q.clk_s = q.clk_m;
      next_q.clk_d = q.clk_s;
      next_q.dat_m = link_data;
      next_q.dat_s = q.dat_m;
      next_q.use_m = link_other_use;
      next_q.use_s = q.use_m;
      if (take) begin
         next_q.didx = q.didx + 4'h1;
         if (!kvl_odd(core_data)) begin
            next_q.xerr = 1'b1;
         end
      end
      case (q.st)
         S_IDLE: begin
            if (panel.standby_req) begin
               next_q.st = S_STANDBY;
               next_q.operable = 1'b0;
            end else if (panel.load_req && !q.use_s) begin
               next_q.st = S_REQ;
               next_q.cnt = '0;
               next_q.perr = 1'b0;
               next_q.xerr = 1'b0;
               // a new entry voids the report of the previous one
               next_q.loaded = 1'b0;
            end else if (panel.sym_valid) begin
               next_q.st = S_MANUAL;
               next_q.key = {60'h0, panel.sym_value};
               next_q.disp = {60'h0, panel.sym_value};
               next_q.mcnt = 5'h01;
               next_q.perr = 1'b0;
               next_q.xerr = 1'b0;
               next_q.loaded = 1'b0;
            end
         end
         S_MANUAL: begin
            if (panel.restart) begin
               next_q.key = '0;
               next_q.mcnt = '0;
            end else if (panel.sym_back && q.mcnt != '0) begin
               next_q.key = {4'h0, q.key[63:4]};
               next_q.mcnt = q.mcnt - 5'h01;
            end else if (panel.sym_valid && q.mcnt != 5'(`KVL_SYMBOLS)) begin
               next_q.key = {q.key[59:0], panel.sym_value};
               next_q.mcnt = q.mcnt + 5'h01;
            end else if (panel.enter && q.mcnt == 5'(`KVL_SYMBOLS)) begin
               next_q.st = S_CHECK;
            end
            next_q.disp = next_q.key;
         end
         S_REQ: begin
            // the spare circuit can lend the lines to other traffic
            if (rise && !q.use_s) begin
               next_q.key = {q.key[62:0], q.dat_s};
               next_q.cnt = q.cnt + 7'h01;
               if (q.cnt == `KVL_LAST_BIT_IDX) begin
                  next_q.st = S_CHECK;
               end
            end
         end
         S_CHECK: begin
            next_q.disp = '0;
            next_q.bidx = '0;
            next_q.didx = '0;
            if (kvl_key_ok(q.key)) begin
               next_q.st = S_PUSH;
            end else begin
               next_q.perr = 1'b1;
               next_q.key = '0;
               next_q.st = S_IDLE;
            end
         end
         S_PUSH: begin
            if (push_ready) begin
               next_q.bidx = q.bidx + 4'h1;
               if (q.bidx == 4'(`KVL_KEY_BYTES - 1)) begin
                  // the key register is cleared here; the bytes stay in the unreset kvl_fifo storage
                  next_q.key = '0;
                  next_q.st = S_DRAIN;
               end
            end
         end
         S_DRAIN: begin
            if (next_q.didx == 4'(`KVL_KEY_BYTES)) begin
               next_q.loaded = !next_q.xerr;
               next_q.st = S_IDLE;
            end
         end
         S_STANDBY: begin
            if (panel.lock_turn) begin
               next_q.operable = 1'b1;
               next_q.st = S_IDLE;
            end
         end
         default: begin
            next_q.st = S_STANDBY;
         end
      endcase
   end

   // comes up in standby so that power alone never restores service
   always_ff @(posedge clk or negedge rst_s) begin
      if (!rst_s) begin
         q <= '0;
         q.st <= S_STANDBY;
         q.operable <= `KVL_RESET_OPERABLE;
      end else begin
         q <= next_q;
      end
   end

   kvl_fifo #(.W(8), .D(`KVL_FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .rst_b(rst_s),
      .in_valid(push),
      .in_ready(push_ready),
      .in_data(push_data),
      .out_valid(core_valid),
      .out_ready(core_ready),
      .out_data(core_data)
   );

   ////////////////////////////////////////////////////////////////////////////
   a_req_level: assert property (@(posedge clk) disable iff (!rst_s)
      (q.st == S_REQ) == !request_b)
      else $error("request level disagrees with state");
   a_req_start: assert property (@(posedge clk) disable iff (!rst_s)
      $fell(request_b) |-> $past(panel.load_req) && $past(q.st) == S_IDLE)
      else $error("request raised without operator load");
   a_req_release: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_REQ && rise && !q.use_s && q.cnt == 7'h3F |=> request_b && q.st == S_CHECK)
      else $error("request not released after last bit");
   a_bit_capture: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_REQ && rise && !q.use_s |=> q.key[0] == $past(q.dat_s)
      && q.key[63:1] == $past(q.key[62:0]))
      else $error("serial bit not shifted in order");
   a_cnt_bound: assert property (@(posedge clk) disable iff (!rst_s)
      q.st != S_REQ |=> $stable(q.cnt) || q.cnt == 7'h00)
      else $error("link clock counted outside a request");
   a_other_use: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_REQ && q.use_s |=> $stable(q.cnt) && $stable(q.key))
      else $error("link taken while spare circuit claims it");
   a_inhibit: assert property (@(posedge clk) disable iff (!rst_s)
      push || core_valid |-> ct_inhibit)
      else $error("ciphertext not inhibited during key move");
   a_parity_fail: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_CHECK && !kvl_key_ok(q.key) |=> q.perr && q.st == S_IDLE
      && q.key == '0 && !push)
      else $error("bad key not discarded");
   a_disp_clear: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_CHECK |=> q.disp == '0)
      else $error("display not cleared after acceptance");
   a_sym_order: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_MANUAL && !panel.restart && !panel.sym_back && panel.sym_valid
      && q.mcnt < 5'h10 |=> q.key[3:0] == $past(panel.sym_value) && q.mcnt == $past(q.mcnt) + 5'h01)
      else $error("symbol not appended");
   a_push_order: assert property (@(posedge clk) disable iff (!rst_s)
      push && q.bidx == 4'h0 |-> push_data == q.key[63:56])
      else $error("first byte is not first_key_bit onward");
   a_xfer_parity: assert property (@(posedge clk) disable iff (!rst_s)
      take && !kvl_odd(core_data) |=> q.xerr)
      else $error("even byte toward core not flagged");
   a_standby: assert property (@(posedge clk) disable iff (!rst_s)
      q.st == S_STANDBY && !panel.lock_turn |=> q.st == S_STANDBY && !operable && ct_inhibit)
      else $error("left standby without lock");
endmodule : kvl_loader

// file: testbench/kvl_far_loader.sv
`timescale 1ns/100ps
// behavioural key loader: link clock stands still outside frames
module kvl_far_loader (
   input wire logic request_b,
   input wire logic [63:0] key,
   input wire logic [3:0] extra,
   output logic link_clk,
   output logic link_data
);
   initial begin
      link_clk = 1'h0;
      link_data = 1'h0;
      forever begin
         @(negedge request_b);
         #330;
         // extra clocks only when the bench asks, to probe the device's bit count
         for (int i = 0; i < 64 + extra; i++) begin
            link_data = key[63 - (i % 64)];
            #80 link_clk = 1'h1;
            #80 link_clk = 1'h0;
         end
         // released line shows no copy of the last key bit
         link_data = ~link_data;
      end
   end
endmodule : kvl_far_loader

// file: testbench/testbench.sv
`timescale 1ns/100ps
module testbench
   import kvl_pkg::*;
;
   localparam logic [10:0] P_LOCK = 11'h001, P_STBY = 11'h002, P_LOAD = 11'h004;
   localparam logic [10:0] P_ENTER = 11'h008, P_RST = 11'h010, P_BACK = 11'h020;
   localparam logic [63:0] KEY_A = 64'h0123456789ABCDEF, KEY_B = 64'hFEDCBA9876543210;
   logic clk = 1'h0, rst_b = 1'h0, link_other_use = 1'h0, core_ready = 1'h0;
   kvl_panel_s panel = '0;
   logic link_clk, link_data, request_b, core_valid, ct_inhibit, key_loaded;
   logic parity_fail, xfer_fail, operable;
   logic [7:0] core_data;
   logic [63:0] disp_digits;
   logic [63:0] far_key = '0;
   logic [3:0] extra = '0;
   int miscompares = 0, n_compared = 0, cycles = 0;

   kvl_loader kvl_loader_inst (.clk(clk), .rst_b(rst_b), .panel(panel), .link_clk(link_clk),
      .link_data(link_data), .link_other_use(link_other_use), .request_b(request_b),
      .core_valid(core_valid), .core_ready(core_ready), .core_data(core_data),
      .ct_inhibit(ct_inhibit), .key_loaded(key_loaded), .parity_fail(parity_fail),
      .xfer_fail(xfer_fail), .operable(operable), .disp_digits(disp_digits));
   kvl_far_loader kvl_far_loader_inst (.request_b(request_b), .key(far_key), .extra(extra),
      .link_clk(link_clk), .link_data(link_data));

   always #10 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////
   function automatic logic [63:0] odd(input logic [63:0] k);
      for (int i = 0; i < 8; i++) k[8*i] = ~^k[8*i+1 +: 7];
      return k;
   endfunction : odd
   function automatic logic [10:0] sym(input logic [3:0] s);
      return {1'h1, s, 6'h00};
   endfunction : sym
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // one-cycle panel pulse, then let the answer land
   task automatic poke(input logic [10:0] v);
      panel = kvl_panel_s'(v);
      @(negedge clk);
      panel = '0;
      repeat (2) @(negedge clk);
   endtask : poke
   // core stalls every other cycle while bytes come out
   task automatic drain(input logic [63:0] k);
      int n = 0;
      int t = 0;
      while (n < 8 && t < 200) begin
         @(negedge clk);
         t++;
         core_ready = t[0];
         if (core_ready && core_valid) begin
            check(ct_inhibit, 1'h1);
            check(core_data, k[63-8*n -: 8]);
            n++;
         end
      end
      @(negedge clk);
      core_ready = 1'h0;
      check(n, 8);
      repeat (3) @(negedge clk);
      check(key_loaded, 1'h1);
      check(ct_inhibit, 1'h0);
   endtask : drain
   task automatic serial(input logic [63:0] k, input logic [3:0] x);
      int t = 0;
      far_key = k;
      extra = x;
      poke(P_LOAD);
      check(request_b, 1'h0);
      check(ct_inhibit, 1'h1);
      // spare circuit borrows the lines before the first link clock; no bit may be lost
      link_other_use = 1'h1;
      repeat (6) @(negedge clk);
      link_other_use = 1'h0;
      while (request_b !== 1'h1 && t < 2000) begin
         @(negedge clk);
         t++;
      end
      check(request_b, 1'h1);
      // surplus link clocks must die out before the next request, or they count in it
      repeat (3 + 8 * x) @(negedge clk);
   endtask : serial
   task automatic test_serial;
      serial(odd(KEY_A), 4'h3);
      check(parity_fail, 1'h0);
      drain(odd(KEY_A));
      serial(odd(KEY_B), 4'h0);
      drain(odd(KEY_B));
      $display("test serial done");
   endtask : test_serial
   task automatic test_parity;
      serial(odd(KEY_B) ^ 64'h0000000000000100, 4'h0);
      check(parity_fail, 1'h1);
      check(core_valid, 1'h0);
      check(key_loaded, 1'h0);
      $display("test parity done");
   endtask : test_parity
   task automatic test_manual;
      logic [63:0] k;
      k = odd(64'h3C5A96F00F69A5C3);
      poke(sym(4'h9));
      check(disp_digits, 64'h9);
      poke(sym(4'h9));
      poke(P_RST);
      check(disp_digits, 64'h0);
      for (int i = 15; i >= 0; i--) begin
         if (i == 0) begin
            poke(sym(~k[3:0]));
            poke(P_BACK);
         end
         poke(sym(k[4*i +: 4]));
      end
      check(disp_digits, k);
      poke(P_ENTER);
      check(disp_digits, 64'h0);
      drain(k);
      check(parity_fail, 1'h0);
      $display("test manual done");
   endtask : test_manual
   task automatic test_other_use;
      link_other_use = 1'h1;
      repeat (3) @(negedge clk);
      poke(P_LOAD);
      check(request_b, 1'h1);
      link_other_use = 1'h0;
      repeat (3) @(negedge clk);
      $display("test other use done");
   endtask : test_other_use
   task automatic test_standby;
      poke(P_STBY);
      check(operable, 1'h0);
      check(ct_inhibit, 1'h1);
      poke(P_LOAD);
      check(request_b, 1'h1);
      poke(P_LOCK);
      check(operable, 1'h1);
      rst_b = 1'h0;
      repeat (2) @(negedge clk);
      rst_b = 1'h1;
      repeat (4) @(negedge clk);
      check(operable, 1'h0);
      $display("test standby done");
   endtask : test_standby
   task automatic print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (12) @(negedge clk);
      rst_b = 1'h1;
      repeat (4) @(negedge clk);
      check(operable, 1'h0);
      check(request_b, 1'h1);
      check(ct_inhibit, 1'h1);
      poke(P_LOCK);
      check(operable, 1'h1);
      $display("test reset done");
      test_serial();
      test_parity();
      test_manual();
      test_other_use();
      test_standby();
      print_verdict();
   end
endmodule : testbench
